// ===== src/pmc_pkg.sv
package pmc_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ACT_TMPL_OFS  = 8'h00;
  localparam logic [7:0] ALT_TMPL_OFS  = 8'h04;
  localparam logic [7:0] MODE_REQ_OFS  = 8'h08;
  localparam logic [7:0] REG_CTRL_OFS  = 8'h0c;
  localparam logic [7:0] WAKE_EN_OFS   = 8'h10;
  localparam logic [7:0] TIMER_OFS     = 8'h14;
  localparam logic [7:0] STATUS_OFS    = 8'h18;

  localparam int          NUM_SUBSYS   = 8;
  localparam int          CPU_BIT      = 0;
  localparam int          FLASH_BIT    = 1;
  localparam int          NUM_WAKE     = 8;
  localparam int          WAKE_PIN_BIT = 0;
  localparam int          WAKE_TMR_BIT = 1;

  localparam logic [7:0]  ACT_TMPL_RST = 8'hff;
  localparam logic [7:0]  ALT_TMPL_RST = 8'hfc;
  localparam logic [7:0]  WAKE_EN_RST  = 8'h00;

  // reg_ctrl fields
  localparam int REG_DIG_BIT = 0;
  localparam int REG_ANA_BIT = 1;

  // mode request codes
  localparam logic [1:0] REQ_NONE  = 2'h0;
  localparam logic [1:0] REQ_ALT   = 2'h1;
  localparam logic [1:0] REQ_SLEEP = 2'h2;
  localparam logic [1:0] REQ_HIB   = 2'h3;

  // timer control fields
  localparam int TMR_RST_BIT   = 16;
  localparam int TMR_WIDTH     = 13;
  localparam int TMR_CMP_WIDTH = 13;

  // timing
  localparam int CLK_HZ       = 250_000_000;
  localparam int SLOW_HZ      = 1_000;
  localparam int SLOW_DIV     = CLK_HZ / SLOW_HZ;
  localparam int BUZZ_PERIOD  = 64;
  localparam int BUZZ_ON      = 8;

  // global mode, gray along active->alt->sleep->hibernate
  typedef enum logic [1:0] {
    PMC_ACTIVE = 2'b00,
    PMC_ALT    = 2'b01,
    PMC_SLEEP  = 2'b11,
    PMC_HIB    = 2'b10
  } pmc_mode_e;

endpackage : pmc_pkg

// ===== src/pmc_power_mode_controller.sv
`timescale 1ns/1ns
// Overview of operation
// - four modes: active, alt, sleep, hibernate
// - active template bit per subsystem
// - disabled subsystem: clock gated, bias off
// - template changes apply at once
// - cpu self-disable, back on at wakeup
// - wakeup forces active and cpu on
// - mode is active after reset
// - alternate active uses smaller template
// - sleep disables all subsystems; timer stays
// - sleep buzzes core regulators
// - hibernate stops clocks; pin wake only
// - hibernate: only hibernate regulator on
// - core regulators on after reset; firmware disables
// - wake from enabled interrupts, the wake pin (not gated by wake enable) or reset
// - 13-bit free-running 1 khz timer, resettable
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // cpu and wake sources
  input  wire logic                  cpu_wfi_i,
  input  wire logic [NUM_WAKE-1:0]   wake_irq_i,
  input  wire logic                  pin_wake_i,
  input  wire logic                  io_supply_ok_i,
  // power control outputs
  output logic [NUM_SUBSYS-1:0]      clk_en_o,
  output logic [NUM_SUBSYS-1:0]      bias_en_o,
  output logic                       dig_reg_en_o,
  output logic                       ana_reg_en_o,
  output logic                       sleep_reg_en_o,
  output logic                       hib_reg_en_o,
  output logic                       slow_clk_run_o,
  output logic [1:0]                 mode_o
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_WAKE-1:0] irq_s1_q, irq_s2_q;
  logic                pin_s1_q, pin_s2_q, sup_s1_q, sup_s2_q;

  always_ff @(posedge clk_i) begin
    irq_s1_q <= wake_irq_i;
    irq_s2_q <= irq_s1_q;
    pin_s1_q <= pin_wake_i;
    pin_s2_q <= pin_s1_q;
    sup_s1_q <= io_supply_ok_i;
    sup_s2_q <= sup_s1_q;
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pmc_mode_e               mode_q, mode_d;
  logic [NUM_SUBSYS-1:0]   act_tmpl_q, alt_tmpl_q;
  logic [NUM_WAKE-1:0]     wake_en_q;
  logic [1:0]              req_q;
  logic [1:0]              regc_q;
  logic                    cpu_on_q;
  logic [TMR_WIDTH-1:0]    tmr_q;
  logic [TMR_CMP_WIDTH-1:0] tmr_cmp_q;
  logic [31:0]             div_q;
  logic [5:0]              buzz_q;
  logic                    tmr_hit_q;
  logic                    ack_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_act   = bus_wr & (wb_adr_i == ACT_TMPL_OFS);
  wire wr_alt   = bus_wr & (wb_adr_i == ALT_TMPL_OFS);
  wire wr_req   = bus_wr & (wb_adr_i == MODE_REQ_OFS);
  wire wr_regc  = bus_wr & (wb_adr_i == REG_CTRL_OFS);
  wire wr_wen   = bus_wr & (wb_adr_i == WAKE_EN_OFS);
  wire wr_tmr   = bus_req & wb_we_i & (wb_adr_i == TIMER_OFS);
  wire tmr_clr  = wr_tmr & wb_sel_i[2] & wb_dat_i[TMR_RST_BIT];
  wire tmr_ld   = wr_tmr & (&wb_sel_i[1:0]);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      ACT_TMPL_OFS: rd_mux = {24'h0, act_tmpl_q};
      ALT_TMPL_OFS: rd_mux = {24'h0, alt_tmpl_q};
      MODE_REQ_OFS: rd_mux = {30'h0, req_q};
      REG_CTRL_OFS: rd_mux = {30'h0, regc_q};
      WAKE_EN_OFS:  rd_mux = {24'h0, wake_en_q};
      TIMER_OFS:    rd_mux = {3'h0, tmr_q, 3'h0, tmr_cmp_q};
      STATUS_OFS:   rd_mux = {20'h0, 3'h0, sup_s2_q, 3'h0, cpu_on_q,
                              2'h0, mode_q};
      default:      rd_mux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // wake and slow clock
  // ---------------------------------------------------------------
  // 1 khz tick enable
  wire slow_tick = (div_q == SLOW_DIV_P - 1);
  wire tmr_run   = (mode_q != PMC_HIB);
  wire [NUM_WAKE-1:0] wake_vec = irq_s2_q & wake_en_q |
    ({{(NUM_WAKE-1){1'b0}}, tmr_hit_q} << WAKE_TMR_BIT) & wake_en_q;
  // only the pin interrupt unit wakes hibernate
  wire wake = (mode_q == PMC_HIB) ? pin_s2_q : (|wake_vec | pin_s2_q);

  wire go_low = cpu_wfi_i & (req_q != REQ_NONE);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PMC_ACTIVE, PMC_ALT: begin
        if (go_low) begin
          case (req_q)
            REQ_ALT:   mode_d = PMC_ALT;
            REQ_SLEEP: mode_d = PMC_SLEEP;
            REQ_HIB:   mode_d = PMC_HIB;
            default:   mode_d = mode_q;
          endcase
        end
        if (mode_q == PMC_ALT && wake)
          mode_d = PMC_ACTIVE;
      end
      PMC_SLEEP, PMC_HIB: begin
        if (wake)
          mode_d = PMC_ACTIVE;
      end
      default: mode_d = PMC_ACTIVE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q     <= PMC_ACTIVE;
      act_tmpl_q <= ACT_TMPL_RST;
      alt_tmpl_q <= ALT_TMPL_RST;
      wake_en_q  <= WAKE_EN_RST;
      req_q      <= REQ_NONE;
      // core regulators on out of reset
      regc_q     <= 2'h3;
      cpu_on_q   <= 1'b1;
      ack_q      <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ack_q  <= bus_req;
      if (wr_act)
        act_tmpl_q <= wb_dat_i[NUM_SUBSYS-1:0];
      if (wr_alt)
        alt_tmpl_q <= wb_dat_i[NUM_SUBSYS-1:0];
      if (wr_wen)
        wake_en_q <= wb_dat_i[NUM_WAKE-1:0];
      if (wr_regc)
        regc_q <= wb_dat_i[1:0];
      // sleep and hibernate requests accepted only with valid io supply
      if (wr_req && (sup_s2_q || wb_dat_i[1:0] == REQ_ALT
                     || wb_dat_i[1:0] == REQ_NONE))
        req_q <= wb_dat_i[1:0];
      else if (go_low)
        req_q <= REQ_NONE;
      // cpu self-disable via template, back on at wake
      if (wake && mode_q != PMC_ACTIVE)
        cpu_on_q <= 1'b1;
      else if (wr_act)
        cpu_on_q <= wb_dat_i[CPU_BIT];
      else if (wake)
        cpu_on_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q     <= 32'h0;
      tmr_q     <= '0;
      tmr_cmp_q <= '0;
      tmr_hit_q <= 1'b0;
      buzz_q    <= 6'h0;
    end else begin
      div_q     <= slow_tick ? 32'h0 : div_q + 32'h1;
      buzz_q    <= buzz_q + 6'h1;
      tmr_hit_q <= 1'b0;
      if (tmr_ld)
        tmr_cmp_q <= wb_dat_i[TMR_CMP_WIDTH-1:0];
      if (tmr_clr)
        tmr_q <= '0;
      else if (slow_tick && tmr_run) begin
        tmr_q     <= tmr_q + 1'b1;
        tmr_hit_q <= (tmr_q + 1'b1) == tmr_cmp_q && tmr_cmp_q != '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // power outputs
  // ---------------------------------------------------------------
  // template chosen by mode
  wire [NUM_SUBSYS-1:0] tmpl = (mode_q == PMC_ALT) ? alt_tmpl_q
                                                   : act_tmpl_q;
  // sleep and hibernate disable all subsystems
  wire low = (mode_q == PMC_SLEEP) || (mode_q == PMC_HIB);
  wire [NUM_SUBSYS-1:0] cpu_mask = {{(NUM_SUBSYS-1){1'b1}}, cpu_on_q};
  wire [NUM_SUBSYS-1:0] cpu_frc  = {{(NUM_SUBSYS-1){1'b0}}, cpu_on_q};
  // alt mode keeps its own cpu bit
  wire [NUM_SUBSYS-1:0] en_act =
    (mode_q == PMC_ALT) ? tmpl : ((tmpl & cpu_mask) | cpu_frc);
  wire [NUM_SUBSYS-1:0] en_d = low ? '0 : en_act;
  wire buzz_on = (buzz_q < 6'(BUZZ_ON));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_o       <= ACT_TMPL_RST;
      bias_en_o      <= ACT_TMPL_RST;
      dig_reg_en_o   <= 1'b1;
      ana_reg_en_o   <= 1'b1;
      sleep_reg_en_o <= 1'b1;
      hib_reg_en_o   <= 1'b1;
      slow_clk_run_o <= 1'b1;
      mode_o         <= PMC_ACTIVE;
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0;
    end else begin
      clk_en_o       <= en_d;
      bias_en_o      <= en_d;
      dig_reg_en_o   <= regc_q[REG_DIG_BIT] & (mode_q == PMC_SLEEP
                        ? buzz_on : mode_q != PMC_HIB);
      ana_reg_en_o   <= regc_q[REG_ANA_BIT] & (mode_q == PMC_SLEEP
                        ? buzz_on : mode_q != PMC_HIB);
      sleep_reg_en_o <= (mode_q != PMC_HIB);
      hib_reg_en_o   <= 1'b1;
      slow_clk_run_o <= tmr_run;
      mode_o         <= mode_q;
      wb_ack_o       <= bus_req;
      wb_dat_o       <= rd_mux;
    end
  end

endmodule : pmc_power_mode_controller

// ===== testbench/pmc_power_mode_controller_properties.sv
`timescale 1ns/1ns
module pmc_power_mode_controller_properties
  import pmc_pkg::*;
#(
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  cpu_wfi_i,
  input wire logic [NUM_WAKE-1:0]   wake_irq_i,
  input wire logic                  pin_wake_i,
  input wire logic                  io_supply_ok_i,
  input wire logic [NUM_SUBSYS-1:0] clk_en_o,
  input wire logic [NUM_SUBSYS-1:0] bias_en_o,
  input wire logic                  dig_reg_en_o,
  input wire logic                  ana_reg_en_o,
  input wire logic                  sleep_reg_en_o,
  input wire logic                  hib_reg_en_o,
  input wire logic                  slow_clk_run_o,
  input wire logic [1:0]            mode_o
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RST_ACTIVE: assert property (
    $fell(rst_i) |-> mode_o == PMC_ACTIVE && clk_en_o == 8'hff)
    else $error("not active after reset");
  AST_BIAS_CLK: assert property (bias_en_o == clk_en_o)
    else $error("bias and clock enables differ");
  AST_MODE_WFI: assert property (
    $changed(mode_o) && mode_o != PMC_ACTIVE |-> $past(cpu_wfi_i, 2))
    else $error("low-power entry without wfi");
  AST_WAKE_CPU: assert property (
    $changed(mode_o) && mode_o == PMC_ACTIVE |-> clk_en_o[CPU_BIT])
    else $error("cpu off on return to active");
  AST_SLEEP_OFF: assert property (
    mode_o == PMC_SLEEP |-> !clk_en_o[CPU_BIT] && slow_clk_run_o)
    else $error("sleep resources wrong");
  AST_BUZZ: assert property (
    (mode_o == PMC_SLEEP && dig_reg_en_o)[*8] ##1 mode_o == PMC_SLEEP
    |-> !dig_reg_en_o)
    else $error("regulator not buzzed in sleep");
  AST_HIB_CLK: assert property (
    mode_o == PMC_HIB |-> clk_en_o == 8'h00 && !slow_clk_run_o)
    else $error("clocks running in hibernate");
  AST_HIB_REG: assert property (mode_o == PMC_HIB |->
    !dig_reg_en_o && !ana_reg_en_o && !sleep_reg_en_o && hib_reg_en_o)
    else $error("regulators wrong in hibernate");
endmodule : pmc_power_mode_controller_properties

bind pmc_power_mode_controller pmc_power_mode_controller_properties
  #(.SLOW_DIV_P(SLOW_DIV_P)) u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .cpu_wfi_i, .wake_irq_i, .pin_wake_i, .io_supply_ok_i, .clk_en_o,
  .bias_en_o, .dig_reg_en_o, .ana_reg_en_o, .sleep_reg_en_o,
  .hib_reg_en_o, .slow_clk_run_o, .mode_o);

// ===== testbench/pmc_power_mode_controller_bench.sv
`timescale 1ns/1ns
module pmc_power_mode_controller_bench
  import pmc_pkg::*;
();
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        cpu_wfi_i, pin_wake_i, io_supply_ok_i, slow_clk_run_o;
  logic        dig_reg_en_o, ana_reg_en_o, sleep_reg_en_o, hib_reg_en_o;
  logic [7:0]  wb_adr_i, wake_irq_i, clk_en_o, bias_en_o;
  logic [3:0]  wb_sel_i;
  logic [1:0]  mode_o;
  logic [31:0] wb_dat_i, wb_dat_o, r, s, n;
  int          err_count, compares, cycles;

  // short divider keeps the wake timer quick in simulation
  pmc_power_mode_controller #(.SLOW_DIV_P(8)) dut (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cpu_wfi_i, .wake_irq_i, .pin_wake_i,
    .io_supply_ok_i, .clk_en_o, .bias_en_o, .dig_reg_en_o, .ana_reg_en_o,
    .sleep_reg_en_o, .hib_reg_en_o, .slow_clk_run_o, .mode_o);

  always #2 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cy(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cy

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // held until ack is sampled at an edge; released only after it
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask : wr

  task automatic req(input logic [1:0] c);
    wr(MODE_REQ_OFS, {30'h0, c});
    cpu_wfi_i <= 1'b1;
    cy(6);
    cpu_wfi_i <= 1'b0;
    cy(1);
  endtask : req

  task automatic wake(input logic p);
    wake_irq_i <= p ? 8'h00 : 8'h04;
    pin_wake_i <= p;
    cy(4);
    wake_irq_i <= 8'h00;
    pin_wake_i <= 1'b0;
    cy(6);
  endtask : wake

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 0; rst_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0;
    wb_adr_i = 0; wb_sel_i = 4'hf; wb_dat_i = 0; cpu_wfi_i = 0;
    wake_irq_i = 0; pin_wake_i = 0; io_supply_ok_i = 1;
    cy(16);
    rst_i <= 1'b0;
    cy(4);
    chk(mode_o, PMC_ACTIVE);
    chk({dig_reg_en_o, ana_reg_en_o, hib_reg_en_o}, 3'h7);
    wb(0, ACT_TMPL_OFS, 0, r); chk(r, 32'hff);
    wb(0, ALT_TMPL_OFS, 0, r); chk(r, 32'hfc);
    wb(0, 8'h1c, 0, r); chk(r, 32'h0);
    wr(REG_CTRL_OFS, 32'h0); cy(3);
    chk({dig_reg_en_o, ana_reg_en_o}, 2'h0);
    wr(REG_CTRL_OFS, 32'h3);
    wr(ACT_TMPL_OFS, 32'ha5); cy(3); chk(bias_en_o, 8'ha5);
    wr(ACT_TMPL_OFS, 32'hfe); cy(3); chk(clk_en_o, 8'hfe);
    wr(WAKE_EN_OFS, 32'h06); wake(0); chk(clk_en_o[0], 1'b1);
    wr(ACT_TMPL_OFS, 32'hff);
    wr(MODE_REQ_OFS, {30'h0, REQ_ALT}); cy(8); chk(mode_o, PMC_ACTIVE);
    cpu_wfi_i <= 1'b1; cy(6); cpu_wfi_i <= 1'b0; cy(1);
    chk({mode_o, clk_en_o}, {PMC_ALT, ALT_TMPL_RST});
    wb(0, STATUS_OFS, 0, r); chk(r[8:0], 9'h111);
    wake(0); chk(mode_o, PMC_ACTIVE);
    io_supply_ok_i <= 1'b0; cy(4);
    req(REQ_SLEEP); chk(mode_o, PMC_ACTIVE);
    io_supply_ok_i <= 1'b1; cy(4);
    req(REQ_SLEEP); chk({mode_o, slow_clk_run_o}, {PMC_SLEEP, 1'b1});
    n = 0;
    repeat (64) begin
      @(posedge clk_i);
      n = n + {31'h0, dig_reg_en_o};
    end
    chk(n, BUZZ_ON);
    wake(0); chk(mode_o, PMC_ACTIVE);
    req(REQ_HIB); chk({mode_o, sleep_reg_en_o}, {PMC_HIB, 1'b0});
    wake(0); chk(mode_o, PMC_HIB);
    wake(1); chk(mode_o, PMC_ACTIVE);
    wr(TIMER_OFS, 32'h10000); wb(0, TIMER_OFS, 0, r); cy(80);
    wb(0, TIMER_OFS, 0, s);
    chk(32'(s[28:16] - r[28:16] inside {[13'd9:13'd11]}), 32'h1);
    // compare of 4 slow ticks lands well after sleep is entered
    wr(TIMER_OFS, 32'h10004); req(REQ_SLEEP);
    chk(mode_o, PMC_SLEEP);
    cy(40); chk(mode_o, PMC_ACTIVE);
    conclude();
  end
endmodule : pmc_power_mode_controller_bench
